// ==== tws_pkg.sv ====
// Constants shared by the three-wire serial port design
package tws_pkg;
  localparam int TWS_ADDR_W = 8;
  localparam logic [7:0] TWS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TWS_ADDR_STAT = 8'h04;
  localparam logic [7:0] TWS_ADDR_DATA = 8'h08;
  localparam logic [7:0] TWS_ADDR_PDAT = 8'h0c;
  localparam logic [7:0] TWS_ADDR_PDIR = 8'h10;
  localparam logic [7:0] TWS_ADDR_ORDR = 8'h14;
  localparam logic [7:0] TWS_ADDR_PINS = 8'h18;
  // Control fields
  localparam int TWS_CTRL_EN = 6;
  localparam int TWS_CTRL_MS = 4;
  localparam int TWS_ORDR_LSB = 0;
  // Status fields
  localparam int TWS_STAT_DONE = 7;
  localparam int TWS_STAT_COLL = 6;
  // Port fields: bits 7..5 of the port words, index 2..0 inside
  localparam int TWS_PORT_LSB = 5;
  localparam int TWS_PIN_SCK = 2;
  localparam int TWS_PIN_SDI = 1;
  localparam int TWS_PIN_SDO = 0;
  // Reset values
  localparam logic [2:0] TWS_PORT_RST = 3'h0;
  localparam logic [7:0] TWS_DATA_RST = 8'h00;
  localparam logic [31:0] TWS_RDATA_RST = 32'h0000_0000;
  // Timing: bits per frame and internal cycles per serial clock half
  localparam int TWS_FRAME_BITS = 8;
  localparam int TWS_HALF_CYC = 2;
  typedef enum logic [2:0] {
    TWS_GEN_IDLE = 3'b001,
    TWS_GEN_LOW = 3'b010,
    TWS_GEN_HIGH = 3'b100
  } tws_gen_e;
endpackage

// ==== tws_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
  parameter int W = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== tws_clkgen.sv ====
// Master serial clock generator: bus clock divided by four, idle high
`timescale 1ns/1ps
`default_nettype none
module tws_clkgen import tws_pkg::*; #(
  parameter int FRAME_BITS = TWS_FRAME_BITS,
  parameter int HALF = TWS_HALF_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  output logic sck_o,
  output logic fall_o,
  output logic rise_o
);
  localparam int HW = $clog2(HALF + 1);
  localparam int BW = $clog2(FRAME_BITS + 1);
  tws_gen_e state;
  tws_gen_e next_state;
  logic [HW-1:0] half;
  logic [HW-1:0] next_half;
  logic [BW-1:0] bits;
  logic [BW-1:0] next_bits;

  // Clock line is high in every state but the low phase
  assign sck_o = (state != TWS_GEN_LOW);

  always_comb begin
    next_state = state;
    next_half = half;
    next_bits = bits;
    fall_o = 1'b0;
    rise_o = 1'b0;
    case (state)
      TWS_GEN_IDLE: begin
        if (start_i && !abort_i) begin
          next_state = TWS_GEN_LOW;
          next_half = '0;
          next_bits = '0;
          fall_o = 1'b1;
        end
      end
      TWS_GEN_LOW: begin
        if (abort_i) begin
          next_state = TWS_GEN_IDLE;
        end else if (half == HW'(HALF - 1)) begin
          next_state = TWS_GEN_HIGH;
          next_half = '0;
          next_bits = bits + BW'(1);
          rise_o = 1'b1;
        end else begin
          next_half = half + HW'(1);
        end
      end
      TWS_GEN_HIGH: begin
        if (abort_i) begin
          next_state = TWS_GEN_IDLE;
        end else if (half == HW'(HALF - 1)) begin
          next_half = '0;
          if (bits == BW'(FRAME_BITS)) begin
            next_state = TWS_GEN_IDLE;
          end else begin
            next_state = TWS_GEN_LOW;
            fall_o = 1'b1;
          end
        end else begin
          next_half = half + HW'(1);
        end
      end
      default: next_state = TWS_GEN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= TWS_GEN_IDLE;
      half <= '0;
      bits <= '0;
    end else begin
      state <= next_state;
      half <= next_half;
      bits <= next_bits;
    end
  end
endmodule
`default_nettype wire

// ==== tws_port.sv ====
// Three-wire synchronous serial port with APB registers and shared pins
//
// Behaviour
// - Master data write loads and starts a frame
// - Serial clock rests high between frames
// - No select line; edges delimit frames
// - Option picks MSB or LSB first
// - Enable bit hands pins to port
// - Directions and port data stay after disable
// - Master clock period is four bus cycles
// - Slave clock input, max quarter rate
// - Falling edges start frame and move data
// - Rising edges sample data input
// - Eighth rising edge ends the frame
// - Idle output holds last shifted bit
// - Clear output direction turns driver off
// - Master and slave form 16-bit ring
// - No auto direction, arbitration, mode fault
// - No interrupt; software polls status
// - Done flag set, cleared status-then-data
// - Data access mid-frame sets collision
// - Master bit drives clock pin; reset clears
// - Disable mid-frame aborts, clears counter
`timescale 1ns/1ps
`default_nettype none
module tws_port import tws_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [TWS_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sck_in_i,
  output logic sck_out_o,
  output logic sck_oe_o,
  input wire logic sdi_in_i,
  output logic sdi_out_o,
  output logic sdi_oe_o,
  input wire logic sdo_in_i,
  output logic sdo_out_o,
  output logic sdo_oe_o
);
  function automatic logic [31:0] tws_port_word(input logic [2:0] v);
    tws_port_word = 32'(v) << TWS_PORT_LSB;
  endfunction

  logic en, next_en;
  logic ms, next_ms;
  logic lsb, next_lsb;
  logic [2:0] pdat, next_pdat;
  logic [2:0] pdir, next_pdir;
  logic [7:0] serial_data_reg, next_sdr;
  logic done, next_done;
  logic coll, next_coll;
  logic arm, next_arm;
  logic busy, next_busy;
  logic [2:0] cnt, next_cnt;
  logic sck_d, next_sck_d;
  logic [1:0] rise_p, next_rise_p;
  logic [31:0] next_prdata;
  logic [2:0] pin_s;
  logic gen_sck, gen_fall, gen_rise;
  logic setup, acc, wr, rd, mapped;
  logic hit_ctrl, hit_stat, hit_data, hit_pdat, hit_pdir, hit_ordr, hit_pins;
  logic data_acc, master_go, en_off, fall, rise, s_fall, s_rise;

  // Slave clock and data pass two flops before any logic sees them
  tws_sync #(.W(3)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i({sck_in_i, sdi_in_i, sdo_in_i}),
    .sync_o(pin_s)
  );

  tws_clkgen u_gen (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(master_go),
    .abort_i(en_off),
    .sck_o(gen_sck),
    .fall_o(gen_fall),
    .rise_o(gen_rise)
  );

  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i;
  assign rd = acc && !pwrite_i;
  assign hit_ctrl = (paddr_i == TWS_ADDR_CTRL);
  assign hit_stat = (paddr_i == TWS_ADDR_STAT);
  assign hit_data = (paddr_i == TWS_ADDR_DATA);
  assign hit_pdat = (paddr_i == TWS_ADDR_PDAT);
  assign hit_pdir = (paddr_i == TWS_ADDR_PDIR);
  assign hit_ordr = (paddr_i == TWS_ADDR_ORDR);
  assign hit_pins = (paddr_i == TWS_ADDR_PINS);
  assign mapped = hit_ctrl || hit_stat || hit_data || hit_pdat ||
                  hit_pdir || hit_ordr || hit_pins;
  // Zero wait states: read data is registered during the setup cycle
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;

  // Data register is reachable only while the port is enabled
  assign data_acc = acc && hit_data && en;
  assign master_go = wr && hit_data && en && ms && !busy;
  assign en_off = wr && hit_ctrl && en && !pwdata_i[TWS_CTRL_EN];
  // Edge detect reads only the second synchroniser stage and its copy
  assign s_fall = sck_d && !pin_s[TWS_PIN_SCK];
  assign s_rise = !sck_d && pin_s[TWS_PIN_SCK];
  assign fall = en && (ms ? gen_fall : s_fall);
  // Master mode samples two cycles after the clock rises, so the input
  // synchroniser has caught up with the level the pin held at the edge
  assign rise = en && (ms ? rise_p[1] : s_rise);

  always_comb begin
    next_en = en;
    next_ms = ms;
    next_lsb = lsb;
    next_pdat = pdat;
    next_pdir = pdir;
    next_sdr = serial_data_reg;
    next_done = done;
    next_coll = coll;
    next_arm = arm;
    next_busy = busy;
    next_cnt = cnt;
    next_sck_d = pin_s[TWS_PIN_SCK];
    next_rise_p = {rise_p[0], gen_rise};
    next_prdata = prdata_o;
    if (wr && hit_ctrl) begin
      next_en = pwdata_i[TWS_CTRL_EN];
      next_ms = pwdata_i[TWS_CTRL_MS];
      if (pwdata_i[TWS_CTRL_EN]) begin
        next_pdir[TWS_PIN_SCK] = pwdata_i[TWS_CTRL_MS];
        if (!en) begin
          next_pdir[TWS_PIN_SDI] = 1'b0;
          next_pdir[TWS_PIN_SDO] = 1'b1;
        end
      end
    end
    if (wr && hit_pdat) begin
      next_pdat = pwdata_i[TWS_PORT_LSB +: 3];
    end
    if (wr && hit_pdir) begin
      next_pdir = pwdata_i[TWS_PORT_LSB +: 3];
    end
    if (wr && hit_ordr) begin
      next_lsb = pwdata_i[TWS_ORDR_LSB];
    end
    if (rd && hit_stat && done) begin
      next_arm = 1'b1;
    end
    // A clear in the cycle of a new set loses: the set is assigned after it and wins
    if (data_acc) begin
      if (pwrite_i) begin
        next_sdr = pwdata_i[7:0];
      end
      if (arm) begin
        next_done = 1'b0;
        next_coll = 1'b0;
        next_arm = 1'b0;
      end
      if (busy) begin
        next_coll = 1'b1;
      end
    end
    if (rise && busy) begin
      next_sdr = lsb ? {pin_s[TWS_PIN_SDI], serial_data_reg[7:1]}
                     : {serial_data_reg[6:0], pin_s[TWS_PIN_SDI]};
      next_cnt = cnt + 3'h1;
      if (cnt == 3'(TWS_FRAME_BITS - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_cnt = 3'h0;
      end
    end
    // Output bit lives in the port data bit, so it survives disable.
    // It comes from the updated shifter: the starting write and, in
    // master mode, the late sample share a cycle with the falling edge.
    if (fall) begin
      next_pdat[TWS_PIN_SDO] = lsb ? next_sdr[0]
                                   : next_sdr[7];
      next_busy = 1'b1;
    end
    if (en_off) begin
      next_busy = 1'b0;
      next_cnt = 3'h0;
      next_coll = 1'b0;
    end
    if (setup) begin
      case (paddr_i)
        TWS_ADDR_CTRL: next_prdata = (32'(en) << TWS_CTRL_EN) |
                                     (32'(ms) << TWS_CTRL_MS);
        TWS_ADDR_STAT: next_prdata = (32'(done) << TWS_STAT_DONE) |
                                     (32'(coll) << TWS_STAT_COLL);
        TWS_ADDR_DATA: next_prdata = en ? 32'(serial_data_reg) : 32'h0000_0000;
        TWS_ADDR_PDAT: next_prdata = tws_port_word(pdat);
        TWS_ADDR_PDIR: next_prdata = tws_port_word(pdir);
        TWS_ADDR_ORDR: next_prdata = 32'(lsb) << TWS_ORDR_LSB;
        TWS_ADDR_PINS: next_prdata = tws_port_word(pin_s);
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      en <= 1'b0;
      ms <= 1'b0;
      lsb <= 1'b0;
      pdat <= TWS_PORT_RST;
      pdir <= TWS_PORT_RST;
      serial_data_reg <= TWS_DATA_RST;
      done <= 1'b0;
      coll <= 1'b0;
      arm <= 1'b0;
      busy <= 1'b0;
      cnt <= 3'h0;
      sck_d <= 1'b1;
      rise_p <= 2'h0;
      prdata_o <= TWS_RDATA_RST;
    end else begin
      en <= next_en;
      ms <= next_ms;
      lsb <= next_lsb;
      pdat <= next_pdat;
      pdir <= next_pdir;
      serial_data_reg <= next_sdr;
      done <= next_done;
      coll <= next_coll;
      arm <= next_arm;
      busy <= next_busy;
      cnt <= next_cnt;
      sck_d <= next_sck_d;
      rise_p <= next_rise_p;
      prdata_o <= next_prdata;
    end
  end

  // Pins follow their direction bits; no automatic turn-around
  assign sck_out_o = (en && ms) ? gen_sck : pdat[TWS_PIN_SCK];
  assign sck_oe_o = pdir[TWS_PIN_SCK];
  assign sdi_out_o = pdat[TWS_PIN_SDI];
  assign sdi_oe_o = pdir[TWS_PIN_SDI];
  assign sdo_out_o = pdat[TWS_PIN_SDO];
  assign sdo_oe_o = pdir[TWS_PIN_SDO];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_low_phase;
    !gen_sck ##1 !gen_sck ##1 gen_sck;
  endsequence

  sequence s_sample(logic b);
    rise && busy && !lsb && cnt != 3'h7 && pin_s[TWS_PIN_SDI] == b;
  endsequence

  AST_START: assert property (
    master_go |=> busy ##0 !gen_sck ##1 !gen_sck ##1 gen_sck)
    else $error("master write did not start a frame");
  AST_SCK_LOW2: assert property (
    $fell(gen_sck) |-> s_low_phase)
    else $error("master clock low phase not two cycles");
  AST_SCK_PERIOD: assert property (
    $fell(gen_sck) ##1 gen_rise |-> ##2 (gen_sck ##1 (busy ? !gen_sck : 1)))
    else $error("master clock period not four cycles");
  AST_IDLE_HIGH: assert property (
    en && ms && !busy && !gen_fall && !(wr && hit_ctrl) |=> sck_out_o)
    else $error("serial clock not high between frames");
  AST_DONE8: assert property (
    rise && busy && cnt == 3'h7 && !en_off |=> done && !busy && cnt == 3'h0)
    else $error("frame did not end on eighth rising edge");
  // Back-to-back bus accesses are three cycles apart
  AST_CLEAR: assert property (
    rd && hit_stat && done ##3 data_acc && !rise |=> !done)
    else $error("done flag not cleared by status then data");
  AST_COLL: assert property (
    data_acc && busy |=> coll)
    else $error("collision flag not set");
  AST_ABORT: assert property (
    en_off |=> !busy && cnt == 3'h0 && !en ##1 gen_sck)
    else $error("disable did not abort the frame");
  AST_DIR: assert property (
    wr && hit_ctrl && !en && pwdata_i[TWS_CTRL_EN]
      |=> !sdi_oe_o && sdo_oe_o && sck_oe_o == ms)
    else $error("enable did not set pin directions");
  AST_SDO_HOLD: assert property (
    !busy && !fall && !(wr && hit_pdat) |=> $stable(sdo_out_o))
    else $error("idle data output changed");
  AST_SDO_OFF: assert property (
    wr && hit_pdir && !pwdata_i[TWS_PORT_LSB + TWS_PIN_SDO] |=> !sdo_oe_o)
    else $error("output driver not turned off");
  AST_SAMPLE: assert property (
    s_sample(1'b1) |=> serial_data_reg[0]) else $error("input bit not sampled");
  AST_SHIFT_OUT: assert property (
    fall |=> sdo_out_o == (lsb ? serial_data_reg[0] : serial_data_reg[7]))
    else $error("presented bit not at the shifter end");
endmodule
`default_nettype wire

// ==== tws_peer.sv ====
// Far-side partner: shift-register peer that can also drive the clock
`timescale 1ns/1ps
`default_nettype none
module tws_peer (
  input wire logic drive_clk_i,
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic lsb_first_i,
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic sdi_o,
  output logic [7:0] data_o
);
  int nbits;
  initial begin
    sck_o = 1'b1;
    sdi_o = 1'b0;
    data_o = 8'h00;
    nbits = 0;
  end
  // Eight 320 ns periods, then the clock stands high again
  always @(posedge drive_clk_i) begin
    #13;
    repeat (8) begin
      sck_o = 1'b0;
      #160;
      sck_o = 1'b1;
      #160;
    end
  end
  always @(posedge load_i) begin
    data_o = load_val_i;
    nbits = 0;
  end
  // Next bit leaves at once on the falling edge
  always @(negedge sck_i) begin
    sdi_o = lsb_first_i ? data_o[0] : data_o[7];
  end
  // Sample on rising edges; after the eighth, once the hold time is over the line moves
  always @(posedge sck_i) begin
    data_o = lsb_first_i ? {sdo_i, data_o[7:1]} : {data_o[6:0], sdo_i};
    nbits = nbits + 1;
    if (nbits == 8) begin
      nbits = 0;
      #120;
      sdi_o = ~sdi_o;
    end
  end
endmodule
`default_nettype wire

// ==== three_wire_sync_serial_port_tb.sv ====
// Self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module three_wire_sync_serial_port_tb import tws_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, tmp;
  logic pready, pslverr, sck_out, sck_oe, sdi_out, sdi_oe, sdo_out, sdo_oe;
  logic sck_w, sdi_w, sdo_w, tog = 1'b0;
  logic peer_clk = 1'b0, peer_ld = 1'b0, lsb = 1'b0, mmode = 1'b0;
  logic [7:0] peer_val = 8'h00, peer_data;
  logic peer_sck, peer_sdi;
  logic [31:0] seed = 32'd37721;
  int fails = 0, n_tests = 0, rises = 0;
  time t_rise = 0, t_fall = 0;

  always #20 clk_sys_i = ~clk_sys_i;
  // Released data line shows a changing pattern, not its last value
  always @(posedge clk_sys_i) tog <= ~tog;
  assign sck_w = sck_oe ? sck_out : peer_sck;
  assign sdi_w = sdi_oe ? sdi_out : peer_sdi;
  assign sdo_w = sdo_oe ? sdo_out : tog;

  tws_port u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sck_in_i(sck_w), .sck_out_o(sck_out),
    .sck_oe_o(sck_oe), .sdi_in_i(sdi_w), .sdi_out_o(sdi_out),
    .sdi_oe_o(sdi_oe), .sdo_in_i(sdo_w), .sdo_out_o(sdo_out),
    .sdo_oe_o(sdo_oe));
  tws_peer u_peer (.drive_clk_i(peer_clk), .load_i(peer_ld),
    .load_val_i(peer_val), .lsb_first_i(lsb), .sck_i(sck_w),
    .sdo_i(sdo_w), .sck_o(peer_sck), .sdi_o(peer_sdi), .data_o(peer_data));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Master clock halves are two bus cycles each
  always @(posedge sck_w) begin
    rises = rises + 1;
    if (mmode) chk(32'($time - t_fall), 32'd80);
    t_rise = $time;
  end
  always @(negedge sck_w) begin
    if (mmode && rises % 8 != 0) chk(32'($time - t_rise), 32'd80);
    t_fall = $time;
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      apb(1'b0, TWS_ADDR_STAT, 32'h0);
      k++;
    end while (rd[TWS_STAT_DONE] !== 1'b1 && k < 60);
    if (rd[TWS_STAT_DONE] !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask
  // One exchange with the peer; the peer clocks it when we are slave
  task automatic frame(input logic m);
    logic [7:0] d, p;
    tmp = rnd();
    d = tmp[7:0];
    p = tmp[15:8];
    peer_val <= p;
    @(posedge clk_sys_i);
    peer_ld <= 1'b1;
    @(posedge clk_sys_i);
    peer_ld <= 1'b0;
    rises = 0;
    apb(1'b1, TWS_ADDR_DATA, {24'h0, d});
    if (!m) begin
      peer_clk <= 1'b1;
      @(posedge clk_sys_i);
      peer_clk <= 1'b0;
    end
    wait_done();
    chk(rises, 32'd8);
    chk({24'h0, peer_data}, {24'h0, d});
    chk({31'h0, sdo_w}, {31'h0, lsb ? d[7] : d[0]});
    chk({31'h0, sck_w}, 32'h1);
    apb(1'b0, TWS_ADDR_DATA, 32'h0);
    chk(rd, {24'h0, p});
    apb(1'b0, TWS_ADDR_STAT, 32'h0);
    chk(rd, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    apb(1'b0, TWS_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, sck_oe}, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, TWS_ADDR_PDAT, 32'h60);
    apb(1'b1, TWS_ADDR_CTRL, 32'h50);
    chk({27'h0, sck_oe, sdi_oe, sdo_oe, sck_w, sdo_w}, 32'h17);
    chk({31'h0, sdi_out}, 32'h1);
    apb(1'b0, TWS_ADDR_PINS, 32'h0);
    chk(rd, 32'ha0);
    mmode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      lsb = i[0];
      apb(1'b1, TWS_ADDR_ORDR, {31'h0, lsb});
      frame(1'b1);
    end
    // Data access mid-frame flags a collision
    apb(1'b1, TWS_ADDR_DATA, 32'h5a);
    apb(1'b1, TWS_ADDR_DATA, 32'h3c);
    apb(1'b0, TWS_ADDR_STAT, 32'h0);
    chk(rd, 32'h40);
    wait_done();
    chk(rd, 32'hc0);
    apb(1'b0, TWS_ADDR_DATA, 32'h0);
    apb(1'b0, TWS_ADDR_STAT, 32'h0);
    chk(rd, 32'h0);
    // Disable in mid-frame, then a full frame after re-enable
    mmode = 1'b0;
    apb(1'b1, TWS_ADDR_DATA, 32'h81);
    apb(1'b1, TWS_ADDR_CTRL, 32'h10);
    chk({31'h0, sck_w}, 32'h0);
    apb(1'b0, TWS_ADDR_PDIR, 32'h0);
    chk(rd, 32'ha0);
    apb(1'b0, TWS_ADDR_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, TWS_ADDR_CTRL, 32'h50);
    mmode = 1'b1;
    frame(1'b1);
    apb(1'b1, TWS_ADDR_PDIR, 32'h80);
    chk({31'h0, sdo_oe}, 32'h0);
    apb(1'b1, TWS_ADDR_PDIR, 32'ha0);
    mmode = 1'b0;
    apb(1'b1, TWS_ADDR_CTRL, 32'h40);
    chk({31'h0, sck_oe}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lsb = i[0];
      apb(1'b1, TWS_ADDR_ORDR, {31'h0, lsb});
      frame(1'b0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
